// ---- shared/sled_map.vh ----
/*
 * Constants for the status LED error signaling block.
 * Assumes a 100 MHz system clock; times in ms except the fast period in us, counts derived.
 */
`ifndef SLED_MAP_VH
`define SLED_MAP_VH

`define SLED_CLK_HZ          100000000
`define SLED_WDOG_PERIOD_MS  200
`define SLED_FADE_PERIOD_MS  3000
`define SLED_PULSE_PERIOD_MS 5000
`define SLED_FAST_PERIOD_US  100
`define SLED_COMM_MULT       10
`define SLED_WDOG_CYCLES     ((`SLED_CLK_HZ / 1000) * `SLED_WDOG_PERIOD_MS)
`define SLED_FADE_CYCLES     ((`SLED_CLK_HZ / 1000) * `SLED_FADE_PERIOD_MS)
`define SLED_PULSE_CYCLES    ((`SLED_CLK_HZ / 1000) * `SLED_PULSE_PERIOD_MS)
`define SLED_FAST_CYCLES     ((`SLED_CLK_HZ / 1000000) * `SLED_FAST_PERIOD_US)
`define SLED_SHUTDOWN_BIT    0
`define SLED_PWM_BITS        8

`endif

// ---- core/sled_period_gen.v ----
/*
 * Free-running period counter with a triangle brightness output.
 * Assumes the period is at least 512 cycles.
 */
module sled_period_gen #(
    parameter [31:0] PERIOD = 32'd1000
) (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       restart,
    output reg        half_r,
    output reg  [7:0] level_r
);
    localparam [31:0] HALF = PERIOD / 32'd2;
    localparam [31:0] STEP = HALF / 32'd256;

    reg [31:0] count_r;
    wire [31:0] pos = (count_r < HALF) ? count_r : (PERIOD - 32'd1 - count_r);
    wire [31:0] scaled = pos / STEP;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= 32'h0;
            half_r  <= 1'b0;
            level_r <= 8'h00;
        end else begin
            if (restart || count_r == PERIOD - 32'd1)
                count_r <= 32'h0;
            else
                count_r <= count_r + 32'd1;
            half_r  <= (count_r < HALF);
            level_r <= (scaled > 32'd255) ? 8'hff : scaled[7:0];
        end
    end
endmodule // sled_period_gen

// ---- core/sled_status_led.v ----
/*
 * Error indicator LED driver of the I/O controller, plus link-enable gate.
 * Holds the pattern selection, the sticky watchdog and shutdown flags,
 * the PWM phase for fading patterns and the transfer and retain gates.
 * Assumes error events come from same-clock controller logic; the
 * link-enable pin comes from the host and is synchronised here.
 * Assumes a power cycle drives reset_n low; nothing else clears the
 * sticky flags.
 * Assumes the host keeps a single program on the link at a time.
 */
// Notes on behaviour
// - Dedicated LED reports errors host cannot see.
// - Watchdog trip blinks with 0.2 s period.
// - Watchdog trip latches until power cycle.
// - Low supply with retain fades, 3 s.
// - No retain store during low-supply retain error.
// - Safe shutdown pulses LED, 5 s period.
// - Control byte one bit 0 enters shutdown.
// - Transfers only while link enable closed.
`include "sled_map.vh"

module sled_status_led (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       host_link_enable_output,
    input  wire       spi_comm_error,
    input  wire       watchdog_trip,
    input  wire       supply_low,
    input  wire       retain_enable,
    input  wire       retain_store_req,
    input  wire [7:0] controller_control_byte_one,
    input  wire       control_byte_valid,
    input  wire       spi_xfer_req,
    output reg        error_indicator_led,
    output wire       spi_xfer_allow,
    output wire       retain_store_allow,
    output reg        safe_state_r,
    output reg        wdog_halt_r
);
    // One-hot pattern states
    localparam [4:0] ST_OFF   = 5'h01;
    localparam [4:0] ST_COMM  = 5'h02;
    localparam [4:0] ST_WDOG  = 5'h04;
    localparam [4:0] ST_FADE  = 5'h08;
    localparam [4:0] ST_PULSE = 5'h10;

    // Host link-enable synchroniser stages
    reg        link_s1_r;
    reg        link_s2_r;
    reg        link_s3_r;
    reg        link_en_r;

    // Pattern state and PWM phase
    reg  [4:0] state_r;
    reg  [4:0] state_nxt;
    reg  [7:0] pwm_r;
    reg        led_nxt;

    // Pattern generator outputs
    wire       wdog_half;
    wire       fast_half;
    wire       pulse_half;
    wire [7:0] fade_level;
    wire [7:0] pulse_level;
    wire [7:0] unused_a;
    wire [7:0] unused_b;
    wire       retain_err;

    assign retain_err = supply_low && retain_enable;

    // Duty compare shared by the fade and pulse patterns
    function pwm_below;
        input [7:0] phase;
        input [7:0] level;
        begin
            pwm_below = (phase < level);
        end
    endfunction

    // Highest-priority condition wins
    function [4:0] pick_state;
        input halted;
        input safe;
        input retain;
        input comm;
        begin
            if (halted)
                pick_state = ST_WDOG;
            else if (safe)
                pick_state = ST_PULSE;
            else if (retain)
                pick_state = ST_FADE;
            else if (comm)
                pick_state = ST_COMM;
            else
                pick_state = ST_OFF;
        end
    endfunction

    // Watchdog blink square wave
    sled_period_gen #(
        .PERIOD (`SLED_WDOG_CYCLES)
    ) u_wdog (
        .clk     (clk),
        .reset_n (reset_n),
        .restart (1'b0),
        .half_r  (wdog_half),
        .level_r (unused_a)
    );

    // Very fast blink for link errors
    sled_period_gen #(
        .PERIOD (`SLED_FAST_CYCLES * `SLED_COMM_MULT)
    ) u_fast (
        .clk     (clk),
        .reset_n (reset_n),
        .restart (1'b0),
        .half_r  (fast_half),
        .level_r (unused_b)
    );

    // Fade triangle for the low-supply retain error
    sled_period_gen #(
        .PERIOD (`SLED_FADE_CYCLES)
    ) u_fade (
        .clk     (clk),
        .reset_n (reset_n),
        .restart (1'b0),
        .half_r  (),
        .level_r (fade_level)
    );

    // Pulse envelope for the safe state
    sled_period_gen #(
        .PERIOD (`SLED_PULSE_CYCLES)
    ) u_pulse (
        .clk     (clk),
        .reset_n (reset_n),
        .restart (1'b0),
        .half_r  (pulse_half),
        .level_r (pulse_level)
    );

    // Three-stage sync; change accepted when stages two and three agree
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            link_s1_r <= 1'b0;
            link_s2_r <= 1'b0;
            link_s3_r <= 1'b0;
            link_en_r <= 1'b0;
        end else begin
            link_s1_r <= host_link_enable_output;
            link_s2_r <= link_s1_r;
            link_s3_r <= link_s2_r;
            if (link_s2_r == link_s3_r)
                link_en_r <= link_s3_r;
        end
    end

    assign spi_xfer_allow     = spi_xfer_req && link_en_r && !wdog_halt_r;
    assign retain_store_allow = retain_store_req && !retain_err;

    // Watchdog flag; only a power-on reset clears it
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wdog_halt_r <= 1'b0;
        end else begin
            if (watchdog_trip)
                wdog_halt_r <= 1'b1;
        end
    end

    // Shutdown flag; refused once the watchdog has tripped
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            safe_state_r <= 1'b0;
        end else begin
            if (control_byte_valid && controller_control_byte_one[`SLED_SHUTDOWN_BIT] && !wdog_halt_r)
                safe_state_r <= 1'b1;
        end
    end

    // Priority: watchdog, shutdown, retain, link error
    always @* begin
        state_nxt = pick_state(wdog_halt_r, safe_state_r, retain_err, spi_comm_error || !link_en_r);
    end

    always @* begin
        case (state_r)
            ST_COMM:  led_nxt = fast_half;
            ST_WDOG:  led_nxt = wdog_half;
            ST_FADE:  led_nxt = pwm_below(pwm_r, fade_level);
            ST_PULSE: led_nxt = pulse_half && pwm_below(pwm_r, pulse_level);
            default:  led_nxt = 1'b0;
        endcase
    end

    // Pattern state register
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // PWM phase and registered LED output
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_r               <= 8'h00;
            error_indicator_led <= 1'b0;
        end else begin
            pwm_r               <= pwm_r + 8'h01;
            error_indicator_led <= led_nxt;
        end
    end
endmodule // sled_status_led

// ---- verification/sled_host_model.sv ----
/* Host model: link enable pin and control byte. Assumes bench commands set with NBA. */
module sled_host_model (
    input  logic       clk,
    input  logic       link_cmd,
    input  logic       shut_cmd,
    output logic       host_link_enable_output,
    output logic [7:0] controller_control_byte_one,
    output logic       control_byte_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(negedge clk) begin
        host_link_enable_output <= link_cmd;
        control_byte_valid <= shut_cmd;
        controller_control_byte_one <= shut_cmd ? 8'h01 : 8'hfe;
    end
endmodule // sled_host_model

// ---- verification/sled_status_led_props.sv ----
/* Port checker for sled_status_led. Assumes one clock and async low reset. */
module sled_status_led_props (
    input logic       clk,
    input logic       reset_n,
    input logic       host_link_enable_output,
    input logic       spi_comm_error,
    input logic       watchdog_trip,
    input logic       supply_low,
    input logic       retain_enable,
    input logic       retain_store_req,
    input logic [7:0] controller_control_byte_one,
    input logic       control_byte_valid,
    input logic       spi_xfer_req,
    input logic       error_indicator_led,
    input logic       spi_xfer_allow,
    input logic       retain_store_allow,
    input logic       safe_state_r,
    input logic       wdog_halt_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_XFER: assert property (spi_xfer_allow |-> spi_xfer_req && !wdog_halt_r) else $error("bad xfer");
    AST_LINK: assert property (!host_link_enable_output [*5] |-> !spi_xfer_allow) else $error("link off");
    AST_RET: assert property (retain_store_allow == (retain_store_req && !(supply_low && retain_enable)))
        else $error("retain");
    AST_WDSET: assert property (watchdog_trip |=> wdog_halt_r) else $error("no halt");
    AST_WDHOLD: assert property (wdog_halt_r |=> wdog_halt_r) else $error("halt lost");
    AST_SSET: assert property (control_byte_valid && controller_control_byte_one[0] && !wdog_halt_r |=> safe_state_r)
        else $error("no safe");
    AST_SREF: assert property (wdog_halt_r && !safe_state_r |=> !safe_state_r) else $error("safe when halted");
    AST_DARK: assert property ((!spi_comm_error && host_link_enable_output && !supply_low && !watchdog_trip
        && !wdog_halt_r && !safe_state_r) [*8] |-> !error_indicator_led) else $error("lit");
endmodule // sled_status_led_props
bind sled_status_led sled_status_led_props sled_status_led_props_i (.*);

// ---- verification/sled_status_led_tb.sv ----
/* Bench for sled_status_led. Assumes host model drives link and control byte. */
module sled_status_led_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset_n, link_cmd, shut_cmd, spi_comm_error, watchdog_trip, supply_low, retain_enable;
    logic retain_store_req, spi_xfer_req, host_link_enable_output, control_byte_valid, error_indicator_led;
    logic spi_xfer_allow, retain_store_allow, safe_state_r, wdog_halt_r;
    logic [7:0] controller_control_byte_one;
    int num_errors, n_tests, cyc;
    sled_status_led sled_status_led_i (.*);
    sled_host_model sled_host_model_i (.*);
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task automatic chk(string nm, logic exp, logic got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s exp %b got %b", nm, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic print_verdict;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic t_link;
        link_cmd <= 0;
        spi_xfer_req <= 1;
        tick(12);
        chk("allow_off", 0, spi_xfer_allow);
        link_cmd <= 1;
        tick(12);
        chk("allow_on", 1, spi_xfer_allow);
        chk("led_dark", 0, error_indicator_led);
        $display("t_link done");
    endtask
    task automatic t_ret;
        retain_store_req <= 1;
        supply_low <= 1;
        retain_enable <= 1;
        tick(1);
        chk("ret_blocked", 0, retain_store_allow);
        retain_enable <= 0;
        tick(1);
        chk("ret_ok", 1, retain_store_allow);
        supply_low <= 0;
        $display("t_ret done");
    endtask
    task automatic t_led;
        spi_comm_error <= 1;
        tick(3);
        chk("led_comm", 1, error_indicator_led);
        spi_comm_error <= 0;
        supply_low <= 1;
        retain_enable <= 1;
        tick(3);
        chk("led_fade", 0, error_indicator_led);
        supply_low <= 0;
        retain_enable <= 0;
        tick(3);
        $display("t_led done");
    endtask
    task automatic t_shut(logic halt);
        watchdog_trip <= halt;
        tick(1);
        watchdog_trip <= 0;
        shut_cmd <= 1;
        tick(1);
        shut_cmd <= 0;
        tick(40);
        chk("halt", halt, wdog_halt_r);
        chk("safe", !halt, safe_state_r);
        chk("xfer", !halt, spi_xfer_allow);
        chk("led", halt, error_indicator_led);
        $display("t_shut done");
    endtask
    initial begin
        {reset_n, link_cmd, shut_cmd, spi_comm_error, watchdog_trip} = '0;
        {supply_low, retain_enable, retain_store_req, spi_xfer_req} = '0;
        tick(20);
        reset_n = 1;
        t_link();
        t_ret();
        t_led();
        t_shut(0);
        reset_n = 0;
        tick(20);
        reset_n = 1;
        t_shut(1);
        print_verdict();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            print_verdict();
        end
    end
endmodule // sled_status_led_tb
